// ==== hdl/oser_pkg.sv ====
// Constants for the expandable output serializer and its register slave
package oser_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   // Control fields: word width, rate, expansion role
   localparam int CTRL_WIDTH_LSB = 0;
   localparam int CTRL_DDR_BIT   = 4;
   localparam int CTRL_ROLE_BIT  = 5;
   localparam logic [3:0] CTRL_WIDTH_RESET = 4'h4;
   localparam logic       CTRL_DDR_RESET   = 1'b1;
   localparam logic       CTRL_ROLE_RESET  = 1'b0;
   // Role encoding
   localparam logic PRIMARY_ROLE   = 1'b0;
   localparam logic SECONDARY_ROLE = 1'b1;
   // Status fields
   localparam int STATUS_OK_BIT   = 0;
   localparam int STATUS_WRST_BIT = 1;
   localparam int STATUS_BRST_BIT = 2;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Parallel sizes
   localparam int PAR_BITS = 6;
   localparam int TRI_BITS = 4;
   localparam logic [3:0] TRI_FULL_MAX = 4'h4;
   // Latency in bit-clock cycles per word width, zero marks an illegal width
   localparam logic [4:0] LAT_SDR [0:10] = '{5'h0, 5'h0, 5'h1, 5'h3, 5'h4, 5'h4, 5'h5, 5'h5, 5'h6, 5'h0, 5'h0};
   localparam logic [4:0] LAT_DDR [0:10] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h1, 5'h0, 5'h3, 5'h0, 5'h4, 5'h0, 5'h4};
   // Reset sequencing states
   typedef enum logic [2:0] {
      ST_RUN  = 3'b001,
      ST_WORD = 3'b010,
      ST_BIT  = 3'b100
   } rst_state_type;
endpackage : oser_pkg

// ==== hdl/output_serializer.sv ====
// Expandable parallel-to-serial output unit with 3-state path and register slave
// Functional notes
// - Ratios above 6:1 use a primary/secondary pair, up to 10 DDR, 8 SDR.
// - Primary chain_in takes secondary chain_out; secondary bits follow primary bits.
// - Both units of a pair use the same word width.
// - Secondary loads only par_data positions 3 to 6.
// - Width 7 uses position 3, width 8 positions 3-4, width 10 3-6.
// - Widths 2 to 8 at SDR, and 4, 6, 8, 10 at DDR.
// - Latency runs from capture tick to first serial bit on serial_out.
// - SDR latency 1,3,4,4,5,5,6 cycles for widths 2 to 8.
// - DDR latency 1,3,4,4 cycles for widths 4,6,8,10.
// - Position 1 leaves first, the rest in ascending order.
// - Secondary positions carry the final bits, least to most significant.
// - Each word goes out within one word period, words back to back.
// - Tristate bits serialize like data, same latency, aligned per slot; above width 4 each unit repeats its position 1 bit in every slot.
// - Low tristate bit drives the slot, high bit floats it.
// - reset_input forces word and bit resets together at once.
// - Release retimes first to the word tick, then to the bit clock.
// - Units given the same reset leave it on the same cycle.
// - While in reset, all data flip-flops drive low.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module output_serializer
   import oser_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // AXI4-Lite slave
   input  wire logic [7:0]            awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [7:0]            araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // Fabric side
   input  wire logic [PAR_BITS-1:0]   par_data,
   input  wire logic [TRI_BITS-1:0]   par_tristate,
   input  wire logic                  reset_input,
   output logic                       word_tick,
   // Expansion chain, bit 0 data, bit 1 tristate
   input  wire logic [1:0]            chain_in,
   output logic [1:0]                 chain_out,
   // Serial side
   output logic                       serial_out,
   output logic                       tristate_out
);
   import oser_pkg::*;

   logic [3:0]          width;
   logic                ddr;
   logic                role;
   rst_state_type       rst_state;
   logic [3:0]          cnt;
   logic [PAR_BITS-1:0] cap_d;
   logic [TRI_BITS-1:0] cap_t;
   logic [PAR_BITS-1:0] sh_d;
   logic [PAR_BITS-1:0] sh_t;
   logic [4:0]          cap_age;
   logic [3:0]          load_age;

   // Latency in bit slots; DDR moves two slots per bit-clock cycle
   function automatic logic [4:0] lat_slots(input logic [3:0] w, input logic d);
      logic [4:0] l;
      l = 5'h0;
      if (w <= 4'ha) begin
         l = d ? {LAT_DDR[w][3:0], 1'b0} : LAT_SDR[w];
      end
      return l;
   endfunction : lat_slots

   // Configuration checks and phase decode
   // table reaches width 10 only through a pair
   wire logic [4:0] lat        = lat_slots(width, ddr);
   wire logic       cfg_ok     = (lat != 5'h0);
   wire logic [3:0] last_slot  = width - 4'h1;
   wire logic       word_en    = (cnt >= last_slot);
   wire logic [3:0] next_cnt   = word_en ? 4'h0 : cnt + 4'h1;
   wire logic [4:0] lsum       = lat + {1'b0, width} - 5'h2;
   wire logic [4:0] load_ph    = (lsum >= {1'b0, width}) ? lsum - {1'b0, width} : lsum;
   wire logic       load_now   = ({1'b0, cnt} == load_ph);
   wire logic       word_rst   = (rst_state == ST_WORD);
   wire logic       bit_rst    = (rst_state != ST_RUN);
   wire logic       wr_fire    = !awready && !wready && !bvalid;

   // Load source: with a one-slot latency (SDR width 2) the word bypasses the capture stage
   wire logic [PAR_BITS-1:0] src_d = (lat == 5'h1) ? par_data : cap_d;
   wire logic [TRI_BITS-1:0] src_t = (lat == 5'h1) ? par_tristate : cap_t;
   // secondary keeps positions 3 to 6 only, lowest first
   wire logic [PAR_BITS-1:0] load_d = (role == SECONDARY_ROLE) ? {2'b00, src_d[5:2]} : src_d;
   // narrow words serialize each tristate bit, wide ones repeat position 1
   wire logic [PAR_BITS-1:0] load_t = (width > TRI_FULL_MAX) ? {PAR_BITS{src_t[0]}}
                                                             : {src_t[3], src_t[3], src_t};

   // Register read decode
   logic [31:0] rd_mux;
   logic        rd_err;
   always_comb begin
      rd_mux = 32'h0;
      rd_err = 1'b0;
      if (araddr == CTRL_OFFSET) begin
         rd_mux = {26'h0, role, ddr, width};
      end else if (araddr == STATUS_OFFSET) begin
         rd_mux = {29'h0, bit_rst, word_rst, cfg_ok};
      end else begin
         rd_err = 1'b1;
      end
   end

   // Write channels taken in either order, response once both are held
   logic [7:0]  aw_q;
   logic [31:0] w_q;
   logic [3:0]  s_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         aw_q    <= 8'h0;
         w_q     <= 32'h0;
         s_q     <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_q    <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_q    <= wdata;
            s_q    <= wstrb;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= (aw_q == CTRL_OFFSET || aw_q == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Control register, byte lane 0 only; status writes are ignored
   // width field set per unit
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         width <= CTRL_WIDTH_RESET;
         ddr   <= CTRL_DDR_RESET;
         role  <= CTRL_ROLE_RESET;
      end else if (wr_fire && aw_q == CTRL_OFFSET && s_q[0]) begin
         width <= w_q[CTRL_WIDTH_LSB +: 4];
         ddr   <= w_q[CTRL_DDR_BIT];
         role  <= w_q[CTRL_ROLE_BIT];
      end
   end

   // Read channel, one answer per address
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_mux;
         rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Word divider runs from rst_n alone so units sharing it keep one phase
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt       <= 4'h0;
         word_tick <= 1'b0;
      end else begin
         cnt       <= next_cnt;
         word_tick <= (next_cnt >= last_slot);
      end
   end

   // Reset sequencer; an illegal setting also holds the unit in reset
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rst_state <= ST_WORD;
      end else begin
         case (rst_state)
            ST_RUN:  rst_state <= (reset_input || !cfg_ok) ? ST_WORD : ST_RUN;
            // leave only on the shared word tick
            ST_WORD: rst_state <= (!reset_input && cfg_ok && cnt == last_slot) ? ST_BIT : ST_WORD;
            ST_BIT:  rst_state <= (reset_input || !cfg_ok) ? ST_WORD : ST_RUN;
            default: rst_state <= ST_WORD;
         endcase
      end
   end

   // Word-domain capture
   // word sampled at the tick edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n || word_rst || reset_input) begin
         cap_d <= '0;
         cap_t <= '0;
      end else if (word_en) begin
         cap_d <= par_data;
         cap_t <= par_tristate;
      end
   end

   // Bit-domain shifters; the chain feeds the top so secondary bits follow
   always_ff @(posedge ref_clk) begin
      if (!rst_n || bit_rst || reset_input) begin
         sh_d         <= '0;
         sh_t         <= '0;
         serial_out   <= 1'b0;
         tristate_out <= 1'b0;
      end else begin
         // reload exactly one word period apart
         if (load_now) begin
            sh_d <= load_d;
            sh_t <= load_t;
         end else begin
            // chain bit enters the top slot
            sh_d <= {chain_in[0], sh_d[PAR_BITS-1:1]};
            sh_t <= {chain_in[1], sh_t[PAR_BITS-1:1]};
         end
         // high floats the slot, low drives it
         serial_out   <= sh_d[0];
         tristate_out <= sh_t[0];
      end
   end
   assign chain_out = {sh_t[0], sh_d[0]};

   // Helper ages for the timing checks; cfg_age saturates so old-width words are ignored
   logic [4:0] cfg_age;
   wire logic  cfg_wr = wr_fire && (aw_q == CTRL_OFFSET) && s_q[0];
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cap_age  <= 5'h0;
         load_age <= 4'h0;
         cfg_age  <= 5'h0;
      end else begin
         cap_age  <= word_en ? 5'h0 : cap_age + 5'h1;
         load_age <= load_now ? 4'h0 : load_age + 4'h1;
         cfg_age  <= cfg_wr ? 5'h0 : cfg_age + {4'h0, cfg_age != 5'h1f};
      end
   end

   AST_ENTER_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reset_input |=> word_rst && bit_rst && !serial_out)
      else $error("reset_input did not force both resets");
   AST_RELEASE_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(word_rst) |-> bit_rst ##1 (!bit_rst || $past(reset_input) || !$past(cfg_ok)))
      else $error("bit reset not released one cycle after word reset");
   AST_RELEASE_ON_TICK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(word_rst) |-> $past(word_en) && $past(cnt) == $past(last_slot))
      else $error("reset released off the word tick");
   AST_DATA_LOW_IN_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bit_rst && $past(bit_rst) |-> !serial_out && !tristate_out && sh_d == '0)
      else $error("data flops not low during reset");
   AST_LATENCY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load_now && !word_en && cfg_ok && $stable(width) && $stable(ddr) |-> cap_age == lat - 5'h2)
      else $error("word loaded at wrong latency");
   AST_FIRST_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load_now && !bit_rst && !reset_input |-> ##1 !bit_rst |-> ##1 serial_out == $past(sh_d[0]))
      else $error("first serial bit is not position 1");
   AST_TRI_ALIGN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load_now && !bit_rst && !reset_input |=> sh_t[0] == $past(load_t[0]) && sh_d[0] == $past(load_d[0]))
      else $error("tristate slot not aligned with data slot");
   AST_BACK_TO_BACK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load_now && $past(load_now, 1) == 1'b0 && $stable(width) && $stable(ddr) && $past(cfg_ok)
         && cfg_age == 5'h1f && load_age != 4'h0 |-> load_age == last_slot)
      else $error("words not sent back to back");
   AST_CHAIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !load_now && !bit_rst && !reset_input |=> sh_d[PAR_BITS-1] == $past(chain_in[0]))
      else $error("chain bit not shifted into top slot");
   AST_SECONDARY_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      load_now && role == SECONDARY_ROLE && !bit_rst && !reset_input |=> sh_d[5:4] == 2'b00)
      else $error("secondary loaded positions 1 or 2");
endmodule : output_serializer

// ==== bench/fabric_model.sv ====
// Fabric-side partner that launches parallel words and reset pulses on word ticks
`timescale 1ns/1ps
module fabric_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       word_tick,
   input  wire logic       rst_req,
   output logic [5:0]      par_data,
   output logic [3:0]      par_tristate,
   output logic            reset_input,
   output logic [1:0]      chain_in
);
   integer seed;
   // Quiet values at time zero
   initial begin
      seed = 32'h2b08;
      par_data = 6'h00;
      par_tristate = 4'h0;
      reset_input = 1'b0;
      chain_in = 2'h0;
   end
   // Chain input takes a new random value every cycle so no stale level can pass for data
   always @(posedge ref_clk) begin
      chain_in <= 2'($random(seed));
      if (!rst_n) begin
         par_data <= 6'h00;
         par_tristate <= 4'h0;
         reset_input <= 1'b0;
      end else if (word_tick) begin
         par_data <= 6'($random(seed));
         par_tristate <= 4'($random(seed));
         reset_input <= rst_req && !reset_input;
      end
   end
endmodule : fabric_model

// ==== bench/tb_top.sv ====
// Self-checking bench for one output serializer in primary role
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   import oser_pkg::*;
   typedef struct {int due; logic d; logic t;} slot_type;
   typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} rd_type;
   logic        ref_clk = 0, rst_n = 0, rst_req = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0]  wstrb = 0;
   logic        awready, wready, bvalid, arready, rvalid, word_tick, reset_input, serial_out, tristate_out;
   logic [1:0]  bresp, rresp, chain_in, chain_out;
   logic [31:0] rdata;
   logic [5:0]  par_data;
   logic [3:0]  par_tristate;
   logic        chk_on = 0;
   int          miscompares = 0, checked = 0, cyc = 0, wid = 2, lat = 1, g;
   slot_type    sq[$];
   rd_type      rq[$];
   logic [1:0]  wq[$];
   localparam logic [4:0] MODES [0:6] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h14, 5'h16};

   output_serializer u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .par_data(par_data), .par_tristate(par_tristate), .reset_input(reset_input),
      .word_tick(word_tick), .chain_in(chain_in), .chain_out(), .serial_out(serial_out), .tristate_out(tristate_out));
   fabric_model u_fab (.ref_clk(ref_clk), .rst_n(rst_n), .word_tick(word_tick), .rst_req(rst_req),
      .par_data(par_data), .par_tristate(par_tristate), .reset_input(reset_input), .chain_in(chain_in));

   // Bit clock at 50 MHz
   initial forever #10 ref_clk = ~ref_clk;

   // Note the serial slots each captured word must fill, wide words share one tristate bit
   always @(posedge ref_clk) begin
      cyc++;
      if (chk_on && word_tick === 1'b1)
         for (int k = 0; k < wid; k++)
            sq.push_back('{cyc + lat + k, par_data[k], (wid > 4) ? par_tristate[0] : par_tristate[k]});
   end
   // Compare each slot once the edge that launches it has landed
   always @(posedge ref_clk) begin
      #1;
      if (sq.size() > 0 && sq[0].due == cyc) begin
         `CHK(serial_out, sq[0].d)
         `CHK(tristate_out, sq[0].t)
         void'(sq.pop_front());
      end
   end
   // Bus answers are taken at their handshake edge
   always @(posedge ref_clk) begin : bus_watch
      rd_type e;
      logic [1:0] br;
      if (bvalid === 1'b1 && bready) begin
         br = wq.pop_front();
         `CHK(bresp, br)
      end
      if (rvalid === 1'b1 && rready) begin
         e = rq.pop_front();
         `CHK(rdata & e.m, e.v)
         `CHK(rresp, e.r)
      end
   end

   task close_out;
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic bound(input int n);
      if (n >= 500) begin
         miscompares++;
         $display("[ERR] %0t wait timed out", $time);
         close_out;
      end
   endtask : bound

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      logic ap, dp;
      int   n;
      ap = 1;
      dp = 1;
      n = 0;
      wq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      while ((ap || dp) && n < 500) begin
         @(posedge ref_clk);
         n++;
         if (ap && awready) begin ap = 0; awvalid <= 0; end
         if (dp && wready) begin dp = 0; wvalid <= 0; end
      end
      bound(n);
      bready <= 1;
      do begin @(posedge ref_clk); n++; end while (bvalid !== 1'b1 && n < 500);
      bound(n);
      bready <= 0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic [1:0] r);
      int n;
      n = 0;
      rq.push_back('{v, m, r});
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin @(posedge ref_clk); n++; end while (arready !== 1'b1 && n < 500);
      bound(n);
      arvalid <= 0;
      do begin @(posedge ref_clk); n++; end while (rvalid !== 1'b1 && n < 500);
      bound(n);
      rready <= 0;
      @(posedge ref_clk);
   endtask : rd

   task automatic ticks(input int cnt);
      int c, n;
      c = 0;
      n = 0;
      while (c < cnt && n < 500) begin @(posedge ref_clk); n++; if (word_tick === 1'b1) c++; end
      bound(n);
   endtask : ticks

   // Check a stretch of words, then let every noted slot come out
   task automatic run(input int cnt);
      int n;
      ticks(3);
      chk_on <= 1;
      ticks(cnt);
      chk_on <= 0;
      n = 0;
      while (sq.size() > 0 && n < 500) begin @(posedge ref_clk); n++; end
      bound(n);
   endtask : run

   // Main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1;
      ticks(2);
      rd(CTRL_OFFSET, 32'h14, 32'hffffffff, RESP_OKAY);
      rd(STATUS_OFFSET, 32'h1, 32'hffffffff, RESP_OKAY);
      rd(8'h08, 32'h0, 32'hffffffff, RESP_SLVERR);
      wr(8'h08, 32'h2, 4'hf, RESP_SLVERR);
      wr(STATUS_OFFSET, 32'hffffffff, 4'hf, RESP_OKAY);
      wr(CTRL_OFFSET, 32'h2, 4'h0, RESP_OKAY);
      rd(CTRL_OFFSET, 32'h14, 32'hffffffff, RESP_OKAY);
      for (int i = 0; i < 7; i++) begin
         wr(CTRL_OFFSET, {27'h0, MODES[i]}, 4'h1, RESP_OKAY);
         wid <= MODES[i][3:0];
         lat <= MODES[i][4] ? 2 * LAT_DDR[MODES[i][3:0]] : LAT_SDR[MODES[i][3:0]];
         run(8);
      end
      // Width 5 is not allowed at double rate, so the unit must stay quiet
      wr(CTRL_OFFSET, 32'h15, 4'h1, RESP_OKAY);
      rd(STATUS_OFFSET, 32'h0, 32'h1, RESP_OKAY);
      `CHK(serial_out, 1'b0)
      wr(CTRL_OFFSET, 32'h4, 4'h1, RESP_OKAY);
      wid <= 4;
      lat <= LAT_SDR[4];
      run(4);
      // Reset pulse in mid-stream, then normal words again
      rst_req <= 1;
      g = 0;
      do begin @(posedge ref_clk); g++; end while (reset_input !== 1'b1 && g < 500);
      bound(g);
      rst_req <= 0;
      @(posedge ref_clk);
      `CHK(serial_out, 1'b0)
      `CHK(tristate_out, 1'b0)
      rd(STATUS_OFFSET, 32'h2, 32'h2, RESP_OKAY);
      run(4);
      close_out;
   end
endmodule : tb_top
